// ==== bench/smq_chk.sv ====
`timescale 1ns/1ns
module smq_chk #(
  parameter int NQ = 64
) (
  input wire logic            CLK_I,
  input wire logic            SRST_I,
  input wire logic            CE_I,
  input wire logic            REG_RD_I,
  input wire logic            REG_RACK_O,
  input wire logic            MAN_ACC_STB_I,
  input wire logic            SDRAM_EN_I,
  input wire logic [16:0]     IDLE_CMD_I,
  input wire logic [16:0]     NORM_CMD_I,
  input wire logic [4*NQ-1:0] QUEUE_STAT_I,
  input wire logic [4*NQ-1:0] QUEUE_IE_I,
  input wire logic [NQ-1:0]   QUEUE_IRQ_O,
  input wire logic            MAN_ACTIVE_O,
  input wire logic            MEM_COL_STROBE_N_O,
  input wire logic            MEM_ROW_STROBE_N_O,
  input wire logic            MEM_WRITE_STROBE_N_O,
  input wire logic [1:0]      MEM_BANK_SEL_O,
  input wire logic [11:0]     MEM_ADDR_BUS_O
);
  wire [16:0] pins = {MEM_ADDR_BUS_O, MEM_BANK_SEL_O, MEM_WRITE_STROBE_N_O,
                      MEM_ROW_STROBE_N_O, MEM_COL_STROBE_N_O};
  wire        tk   = CE_I & MAN_ACC_STB_I;
  wire        rk   = CE_I & REG_RD_I;
  logic [NQ-1:0] cause;
  always_comb
  begin
    for (int q = 0; q < NQ; q++)
      cause[q] = |(QUEUE_STAT_I[4*q+:4] & QUEUE_IE_I[4*q+:4]);
  end
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  a_rack_pulse: assert property (rk |=> REG_RACK_O)
    else $error("read not acknowledged");
  a_rack_quiet: assert property (CE_I && !REG_RD_I |=> !REG_RACK_O)
    else $error("acknowledge without read");
  a_rack_freeze: assert property (!CE_I |=> $stable(REG_RACK_O))
    else $error("acknowledge moved while frozen");
  a_man_drive: assert property (tk |=> MAN_ACTIVE_O)
    else $error("manual command missing");
  a_man_single: assert property (tk ##1 (CE_I && !MAN_ACC_STB_I) |->
    MAN_ACTIVE_O ##1 !MAN_ACTIVE_O)
    else $error("manual command not one cycle");
  a_man_quiet: assert property (CE_I && !MAN_ACC_STB_I |=>
    !MAN_ACTIVE_O) else $error("manual command without strobe");
  a_norm_follow: assert property (CE_I && !tk && SDRAM_EN_I |=>
    pins == $past(NORM_CMD_I)) else $error("pins not at normal");
  a_idle_hold: assert property (CE_I && !tk && !SDRAM_EN_I |=>
    pins == $past(IDLE_CMD_I)) else $error("pins not at idle");
  a_irq_track: assert property (CE_I |=> QUEUE_IRQ_O == $past(cause))
    else $error("queue interrupt wrong");
  a_irq_freeze: assert property (!CE_I |=> $stable(QUEUE_IRQ_O))
    else $error("interrupts moved while frozen");
  a_pin_freeze: assert property (!CE_I |=>
    $stable(pins) && $stable(MAN_ACTIVE_O))
    else $error("pins moved while frozen");
endmodule : smq_chk

// ==== bench/smq_sdram_model.sv ====
`timescale 1ns/1ns
module smq_sdram_model (
  input  wire logic        clk_i,
  input  wire logic        col_n_i,
  input  wire logic        row_n_i,
  input  wire logic        we_n_i,
  input  wire logic [1:0]  bank_i,
  input  wire logic [11:0] addr_i,
  output logic      [16:0] cmd_o,
  output int               cnt_o
);
  initial cnt_o = 0;
  // No chip select, so any low strobe counts as a command
  always @(posedge clk_i)
  begin
    if (!(col_n_i & row_n_i & we_n_i))
    begin
      cmd_o <= {addr_i, bank_i, we_n_i, row_n_i, col_n_i};
      cnt_o <= cnt_o + 1;
    end
  end
endmodule : smq_sdram_model

// ==== bench/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
  localparam int NQ = 64;
  logic CLK_I, SRST_I, CE_I, REG_WR_I, REG_RD_I, MAN_ACC_STB_I, SDRAM_EN_I;
  logic REG_RACK_O, MAN_ACTIVE_O, col_n, row_n, we_n;
  logic [11:0] REG_ADDR_I, addr;
  logic [15:0] REG_WDATA_I, REG_RDATA_O;
  logic [16:0] IDLE_CMD_I, NORM_CMD_I, mcmd, ecmd;
  logic [1:0] bank;
  logic [4*NQ-1:0] QUEUE_STAT_I, QUEUE_IE_I;
  logic [NQ-1:0] QUEUE_IRQ_O, exp_q;
  int error_cnt, compares, cyc, mcnt, base, seed;
  wire [16:0] pins = {addr, bank, we_n, row_n, col_n};
  smq_top #(.NQ(NQ)) u_dut (.CLK_I(CLK_I), .SRST_I(SRST_I), .CE_I(CE_I),
    .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I),
    .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O), .REG_RACK_O(REG_RACK_O),
    .MAN_ACC_STB_I(MAN_ACC_STB_I), .SDRAM_EN_I(SDRAM_EN_I),
    .IDLE_CMD_I(IDLE_CMD_I), .NORM_CMD_I(NORM_CMD_I),
    .QUEUE_STAT_I(QUEUE_STAT_I), .QUEUE_IE_I(QUEUE_IE_I),
    .QUEUE_IRQ_O(QUEUE_IRQ_O), .MAN_ACTIVE_O(MAN_ACTIVE_O),
    .MEM_COL_STROBE_N_O(col_n), .MEM_ROW_STROBE_N_O(row_n),
    .MEM_WRITE_STROBE_N_O(we_n), .MEM_BANK_SEL_O(bank),
    .MEM_ADDR_BUS_O(addr));
  smq_sdram_model u_mem (.clk_i(CLK_I), .col_n_i(col_n), .row_n_i(row_n),
    .we_n_i(we_n), .bank_i(bank), .addr_i(addr), .cmd_o(mcmd), .cnt_o(mcnt));
  initial
  begin
    CLK_I = 0;
    forever #25 CLK_I = ~CLK_I;
  end
  always @(posedge CLK_I)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      error_cnt++;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task close_out();
    $display("checks %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  task chk(input logic [63:0] s, input logic [63:0] e, input string n);
    compares++;
    if (s !== e)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge CLK_I);
    #1;
  endtask : tick
  task wr(input logic [11:0] a, input logic [15:0] d);
    tick(1);
    REG_ADDR_I = a;
    REG_WDATA_I = d;
    REG_WR_I = 1;
    tick(1);
    REG_WR_I = 0;
  endtask : wr
  task rd(input logic [11:0] a, input logic [15:0] e, input string n);
    tick(1);
    REG_ADDR_I = a;
    REG_RD_I = 1;
    tick(1);
    REG_RD_I = 0;
    chk(REG_RACK_O, 1, "read ack");
    chk(REG_RDATA_O, e, n);
  endtask : rd
  task stb(input int n);
    tick(1);
    MAN_ACC_STB_I = 1;
    tick(n);
    MAN_ACC_STB_I = 0;
    chk(MAN_ACTIVE_O, CE_I, "man active");
    tick(2);
    chk(MAN_ACTIVE_O, 0, "man done");
  endtask : stb
  task serv();
    for (int q = 0; q < NQ; q++)
      exp_q[q] = |(QUEUE_STAT_I[4*q+:4] & QUEUE_IE_I[4*q+:4]);
    tick(2);
    chk(QUEUE_IRQ_O, exp_q, "irq");
    for (int g = 0; g < 4; g++)
      rd(12'h43e - 12'(2*g), exp_q[16*g+:16], "serv");
  endtask : serv
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    seed = 32'h6b45;
    {CE_I, REG_WR_I, REG_RD_I, MAN_ACC_STB_I, SDRAM_EN_I} = 5'h10;
    {REG_ADDR_I, REG_WDATA_I, QUEUE_STAT_I, QUEUE_IE_I} = '0;
    IDLE_CMD_I = 17'h0001f;
    NORM_CMD_I = 17'h1ffff;
    SRST_I = 1;
    tick(2);
    SRST_I = 0;
    chk(pins, 17'h0001f, "reset pins");
    rd(12'h424, 16'h001f, "cmd reset");
    rd(12'h426, 16'h0000, "addr reset");
    rd(12'h430, 16'h0000, "unmapped");
    serv();
    $display("test reset done");
    for (int i = 0; i < 4; i++)
    begin
      IDLE_CMD_I = {14'($random(seed)), 3'h7};
      ecmd = 17'($random(seed)) & 17'h1fffe;
      // Values loaded before the strobe, memory disabled
      wr(12'h424, {11'h0, ecmd[4:0]});
      wr(12'h426, {4'h0, ecmd[16:5]});
      rd(12'h424, {11'h0, ecmd[4:0]}, "cmd word");
      chk(pins, IDLE_CMD_I, "idle pins");
      base = mcnt;
      stb(1);
      chk(mcmd, ecmd, "manual cmd");
      chk(mcnt - base, 1, "cmd count");
    end
    base = mcnt;
    stb(2);
    chk(mcnt - base, 2, "back to back");
    NORM_CMD_I = {14'($random(seed)), 3'h7};
    SDRAM_EN_I = 1;
    tick(2);
    chk(pins, NORM_CMD_I, "normal pins");
    SDRAM_EN_I = 0;
    tick(2);
    chk(pins, IDLE_CMD_I, "idle again");
    $display("test manual done");
    for (int i = 0; i < 4; i++)
    begin
      for (int j = 0; j < 8; j++)
      begin
        QUEUE_STAT_I[32*j+:32] = $random(seed);
        QUEUE_IE_I[32*j+:32] = $random(seed) & $random(seed) & $random(seed);
      end
      wr(12'h438, 16'hffff);
      serv();
    end
    CE_I = 0;
    QUEUE_STAT_I = ~QUEUE_STAT_I;
    base = mcnt;
    wr(12'h424, 16'h0000);
    stb(1);
    chk(QUEUE_IRQ_O, exp_q, "frozen irq");
    chk(mcnt - base, 0, "frozen cmd");
    CE_I = 1;
    rd(12'h424, {11'h0, ecmd[4:0]}, "frozen word");
    $display("test queue done");
    // Reset again in mid-run with queue causes still present
    SRST_I = 1;
    tick(1);
    SRST_I = 0;
    chk(QUEUE_IRQ_O, 0, "irq reset");
    chk(pins, 17'h0001f, "pins reset");
    chk(MAN_ACTIVE_O, 0, "active reset");
    rd(12'h424, 16'h001f, "cmd re-reset");
    $display("test second reset done");
    close_out();
  end
endmodule : tb_top

bind smq_top smq_chk #(.NQ(NQ)) u_chk (.CLK_I(CLK_I), .SRST_I(SRST_I),
  .CE_I(CE_I), .REG_RD_I(REG_RD_I), .REG_RACK_O(REG_RACK_O),
  .MAN_ACC_STB_I(MAN_ACC_STB_I), .SDRAM_EN_I(SDRAM_EN_I),
  .IDLE_CMD_I(IDLE_CMD_I), .NORM_CMD_I(NORM_CMD_I),
  .QUEUE_STAT_I(QUEUE_STAT_I),
  .QUEUE_IE_I(QUEUE_IE_I), .QUEUE_IRQ_O(QUEUE_IRQ_O),
  .MAN_ACTIVE_O(MAN_ACTIVE_O), .MEM_COL_STROBE_N_O(MEM_COL_STROBE_N_O),
  .MEM_ROW_STROBE_N_O(MEM_ROW_STROBE_N_O),
  .MEM_WRITE_STROBE_N_O(MEM_WRITE_STROBE_N_O),
  .MEM_BANK_SEL_O(MEM_BANK_SEL_O), .MEM_ADDR_BUS_O(MEM_ADDR_BUS_O));

// ==== common/smq_pkg.sv ====
package smq_pkg;

  // Command pin bundle, packed as on the CMD ports of the top
  typedef struct packed {
    logic [11:0] addr;
    logic [1:0]  bank;
    logic        we_n;
    logic        ras_n;
    logic        cas_n;
  } smq_cmd_t;

  // Source that owns the memory pins in a given cycle
  typedef enum logic [1:0] {
    SMQ_SRC_IDLE,
    SMQ_SRC_NORM,
    SMQ_SRC_MAN
  } smq_src_t;

endpackage : smq_pkg

// ==== common/smq_qif.sv ====
`timescale 1ns/1ns
interface smq_qif #(
  parameter int NQ = 64
);
  logic [4*NQ-1:0] stat;
  logic [4*NQ-1:0] ie;
  logic [NQ-1:0]   serv;

  modport src (output stat, output ie, input  serv);
  modport svc (input  stat, input  ie, output serv);
endinterface : smq_qif

// ==== common/smq_regs.svh ====
`ifndef SMQ_REGS_SVH
`define SMQ_REGS_SVH

// Register byte offsets (16-bit words)
`define SMQ_ADDR_W          12
`define SMQ_DATA_W          16
`define SMQ_MAN_CMD_OFS     12'h424
`define SMQ_MAN_ADDR_OFS    12'h426
`define SMQ_SERV_HIGH_OFS   12'h438
`define SMQ_SERV_UMID_OFS   12'h43a
`define SMQ_SERV_LMID_OFS   12'h43c
`define SMQ_SERV_LOW_OFS    12'h43e

// Queue groups behind each summary word
`define SMQ_GRP_HIGH        2'h3
`define SMQ_GRP_UMID        2'h2
`define SMQ_GRP_LMID        2'h1
`define SMQ_GRP_LOW         2'h0
`define SMQ_GRP_SIZE        16

// Manual command word fields
`define SMQ_CAS_BIT         0
`define SMQ_RAS_BIT         1
`define SMQ_WE_BIT          2
`define SMQ_BS_LSB          3
`define SMQ_BS_MSB          4
`define SMQ_MAN_CMD_W       5
`define SMQ_MAN_ADDR_W      12

// Reset values
`define SMQ_MAN_CMD_RST     5'h1f
`define SMQ_MAN_ADDR_RST    12'h000
`define SMQ_SERV_RST        16'h0000
`define SMQ_PIN_STB_RST     1'h1
`define SMQ_PIN_BS_RST      2'h3
`define SMQ_PIN_ADDR_RST    12'h000

// Per-queue status and enable nibble
`define SMQ_Q_BITS          4

`endif

// ==== hw/smq_queue_serv.sv ====
`timescale 1ns/1ns
`include "smq_regs.svh"

module smq_queue_serv #(
  parameter int NQ = 64
) (
  input  wire logic clk_i,
  input  wire logic srst_i,
  input  wire logic ce_i,
  smq_qif.svc       q
);

  logic [NQ-1:0] need_d;
  logic [NQ-1:0] serv_q;

  ////////////////////////////////////////////////////////////////////////////
  // A queue needs service while any status bit meets its enable
  for (genvar g = 0; g < NQ; g++)
  begin : g_q
    assign need_d[g] = |(q.stat[g*`SMQ_Q_BITS +: `SMQ_Q_BITS]
                         & q.ie[g*`SMQ_Q_BITS +: `SMQ_Q_BITS]); // [R10] [R12]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered so the summary and the interrupt lines cannot glitch
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      serv_q <= '0; // [R10]
    else if (ce_i)
      serv_q <= need_d; // [R12]
  end

  assign q.serv = serv_q;

endmodule : smq_queue_serv

// ==== hw/smq_top.sv ====
`timescale 1ns/1ns
`include "smq_regs.svh"

// What this block does
// R1: A manual strobe puts the stored column-strobe value on its pin one cycle.
// R2: The same strobe puts the stored row-strobe value on its pin one cycle.
// R3: The same strobe puts the stored write-strobe value on its pin one cycle.
// R4: The same strobe puts the stored two-bit bank value on the bank pins.
// R5: The same strobe puts the stored twelve-bit address on address pins.
// R6: Queues 48 to 63 report in one word, queue 48 in bit 0.
// R7: Queues 32 to 47 report in one word, queue 32 in bit 0.
// R8: Queues 16 to 31 report in one word, queue 16 in bit 0.
// R9: Queues 0 to 15 report in one word, queue 0 in bit 0.
// R10: Summary bit is one exactly while its queue has enabled status set.
// R11: With memory disabled and no manual cycle, pins hold the idle values.
// R12: Queue interrupt stands while status and enable both set.
// R13: Each strobe write gives one single-cycle command; zero does nothing.
// R14: Software loads values first and strobes only with memory disabled.

module smq_top #(
  parameter int NQ = 64
) (
  input  wire logic          CLK_I,
  input  wire logic          SRST_I,
  input  wire logic          CE_I,
  input  wire logic [11:0]   REG_ADDR_I,
  input  wire logic [15:0]   REG_WDATA_I,
  input  wire logic          REG_WR_I,
  input  wire logic          REG_RD_I,
  output logic      [15:0]   REG_RDATA_O,
  output logic               REG_RACK_O,
  input  wire logic          MAN_ACC_STB_I,
  input  wire logic          SDRAM_EN_I,
  input  wire logic [16:0]   IDLE_CMD_I,
  input  wire logic [16:0]   NORM_CMD_I,
  input  wire logic [4*NQ-1:0] QUEUE_STAT_I,
  input  wire logic [4*NQ-1:0] QUEUE_IE_I,
  output logic      [NQ-1:0] QUEUE_IRQ_O,
  output logic               MAN_ACTIVE_O,
  output logic               MEM_COL_STROBE_N_O,
  output logic               MEM_ROW_STROBE_N_O,
  output logic               MEM_WRITE_STROBE_N_O,
  output logic      [1:0]    MEM_BANK_SEL_O,
  output logic      [11:0]   MEM_ADDR_BUS_O
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [`SMQ_MAN_CMD_W-1:0]  man_cmd_q;
  logic [`SMQ_MAN_ADDR_W-1:0] man_addr_q;
  logic [15:0]                rdata_q;
  logic                       rack_q;
  logic                       man_active_q;
  smq_pkg::smq_cmd_t          pins_q;

  wire                        wr_man_cmd;
  wire                        wr_man_addr;
  wire                        man_fire;
  wire  [15:0]                rdata_d;
  wire  [15:0]                man_cmd_word;
  wire  [15:0]                man_addr_word;
  smq_pkg::smq_cmd_t          man_cmd;
  smq_pkg::smq_cmd_t          idle_cmd;
  smq_pkg::smq_cmd_t          norm_cmd;
  smq_pkg::smq_cmd_t          pins_d;
  smq_pkg::smq_src_t          src;
  wire                        sel_man_cmd;
  wire                        sel_man_addr;
  wire                        sel_serv_high;
  wire                        sel_serv_umid;
  wire                        sel_serv_lmid;
  wire                        sel_serv_low;
  wire  [15:0]                serv_high_word;
  wire  [15:0]                serv_umid_word;
  wire  [15:0]                serv_lmid_word;
  wire  [15:0]                serv_low_word;

  smq_qif #(.NQ(NQ)) qif ();

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // One group of sixteen queue summary bits, lowest queue in bit 0
  function automatic logic [15:0] serv_word(input logic [NQ-1:0] serv,
                                            input logic [1:0]    grp);
    serv_word = serv[grp*`SMQ_GRP_SIZE +: `SMQ_GRP_SIZE];
  endfunction : serv_word

  // Address compare gated by a strobe
  function automatic logic hit(input logic        stb,
                               input logic [11:0] addr,
                               input logic [11:0] ofs);
    hit = stb & (addr == ofs);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  // Queue service summary

  assign qif.stat = QUEUE_STAT_I;
  assign qif.ie   = QUEUE_IE_I;

  smq_queue_serv #(.NQ(NQ)) u_serv (
    .clk_i  (CLK_I),
    .srst_i (SRST_I),
    .ce_i   (CE_I),
    .q      (qif)
  );

  // Straight from the flops inside the summary module
  assign QUEUE_IRQ_O = qif.serv; // [R12]

  ////////////////////////////////////////////////////////////////////////////
  // Register decode

  assign wr_man_cmd  = hit(REG_WR_I, REG_ADDR_I, `SMQ_MAN_CMD_OFS);
  assign wr_man_addr = hit(REG_WR_I, REG_ADDR_I, `SMQ_MAN_ADDR_OFS);

  // Address alone selects; the read strobe only loads rdata_q and rack_q
  assign sel_man_cmd   = hit(1'b1, REG_ADDR_I, `SMQ_MAN_CMD_OFS);
  assign sel_man_addr  = hit(1'b1, REG_ADDR_I, `SMQ_MAN_ADDR_OFS);
  assign sel_serv_high = hit(1'b1, REG_ADDR_I, `SMQ_SERV_HIGH_OFS);
  assign sel_serv_umid = hit(1'b1, REG_ADDR_I, `SMQ_SERV_UMID_OFS);
  assign sel_serv_lmid = hit(1'b1, REG_ADDR_I, `SMQ_SERV_LMID_OFS);
  assign sel_serv_low  = hit(1'b1, REG_ADDR_I, `SMQ_SERV_LOW_OFS);

  // Reserved bits read as zero
  assign man_cmd_word  = {11'h000, man_cmd_q};
  assign man_addr_word = {4'h0, man_addr_q};

  // Summary words, lowest queue of each group in bit 0
  assign serv_high_word = serv_word(qif.serv, `SMQ_GRP_HIGH); // [R6]
  assign serv_umid_word = serv_word(qif.serv, `SMQ_GRP_UMID); // [R7]
  assign serv_lmid_word = serv_word(qif.serv, `SMQ_GRP_LMID); // [R8]
  assign serv_low_word  = serv_word(qif.serv, `SMQ_GRP_LOW);  // [R9]

  // Selects are one-hot, so an OR of gated words is the mux;
  // an unmapped address leaves every term at zero
  assign rdata_d = ({16{sel_man_cmd}}   & man_cmd_word)   |
                   ({16{sel_man_addr}}  & man_addr_word)  |
                   ({16{sel_serv_high}} & serv_high_word) |
                   ({16{sel_serv_umid}} & serv_umid_word) |
                   ({16{sel_serv_lmid}} & serv_lmid_word) |
                   ({16{sel_serv_low}}  & serv_low_word);

  ////////////////////////////////////////////////////////////////////////////
  // Manual value registers

  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      man_cmd_q  <= `SMQ_MAN_CMD_RST;
      man_addr_q <= `SMQ_MAN_ADDR_RST;
    end
    else if (CE_I)
    begin
      if (wr_man_cmd)
        man_cmd_q <= REG_WDATA_I[`SMQ_MAN_CMD_W-1:0];
      if (wr_man_addr)
        man_addr_q <= REG_WDATA_I[`SMQ_MAN_ADDR_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port: data one cycle after the read strobe

  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      rdata_q <= 16'h0000;
      rack_q  <= 1'b0;
    end
    else if (CE_I)
    begin
      rack_q <= REG_RD_I;
      if (REG_RD_I)
        rdata_q <= rdata_d;
    end
  end

  assign REG_RDATA_O = rdata_q;
  assign REG_RACK_O  = rack_q;

  ////////////////////////////////////////////////////////////////////////////
  // Pin source selection

  // Strobe is a write-one pulse, no stored bit to clear
  assign man_fire = MAN_ACC_STB_I; // [R13]

  assign man_cmd.cas_n = man_cmd_q[`SMQ_CAS_BIT];                    // [R1]
  assign man_cmd.ras_n = man_cmd_q[`SMQ_RAS_BIT];                    // [R2]
  assign man_cmd.we_n  = man_cmd_q[`SMQ_WE_BIT];                     // [R3]
  assign man_cmd.bank  = man_cmd_q[`SMQ_BS_MSB:`SMQ_BS_LSB];         // [R4]
  assign man_cmd.addr  = man_addr_q;                                 // [R5]

  assign idle_cmd = smq_pkg::smq_cmd_t'(IDLE_CMD_I);
  assign norm_cmd = smq_pkg::smq_cmd_t'(NORM_CMD_I);

  // Manual wins even if enabled; software is expected not to overlap
  assign src = man_fire   ? smq_pkg::SMQ_SRC_MAN  :                  // [R14]
               SDRAM_EN_I ? smq_pkg::SMQ_SRC_NORM :
                            smq_pkg::SMQ_SRC_IDLE;

  always_comb
  begin
    case (src)
      smq_pkg::SMQ_SRC_MAN:  pins_d = man_cmd;                  // [R1]-[R5]
      smq_pkg::SMQ_SRC_NORM: pins_d = norm_cmd;
      smq_pkg::SMQ_SRC_IDLE: pins_d = idle_cmd;                 // [R11]
      default:               pins_d = idle_cmd;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin registers: one cycle of manual drive per strobe cycle, then back to normal or idle per SDRAM_EN_I

  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      pins_q.cas_n <= `SMQ_PIN_STB_RST;
      pins_q.ras_n <= `SMQ_PIN_STB_RST;
      pins_q.we_n  <= `SMQ_PIN_STB_RST;
      pins_q.bank  <= `SMQ_PIN_BS_RST;
      pins_q.addr  <= `SMQ_PIN_ADDR_RST;
      man_active_q <= 1'b0;
    end
    else if (CE_I)
    begin
      pins_q       <= pins_d;   // [R11] [R13]
      man_active_q <= man_fire; // [R13]
    end
  end

  assign MEM_COL_STROBE_N_O   = pins_q.cas_n;
  assign MEM_ROW_STROBE_N_O   = pins_q.ras_n;
  assign MEM_WRITE_STROBE_N_O = pins_q.we_n;
  assign MEM_BANK_SEL_O       = pins_q.bank;
  assign MEM_ADDR_BUS_O       = pins_q.addr;
  assign MAN_ACTIVE_O         = man_active_q;

endmodule : smq_top
